// [rtl/dcs_sequencer.v]
// Function
// [R1] Enter constant voltage at regulation voltage
// [R2] End cycle when current below selected ratio
// [R3] End cycle when elapse timer expires
// [R4] Termination comparator filtered for one millisecond
// [R5] Elapse period parameter; timer may be disabled
// [R6] Charge complete restarts below recharge threshold
// [R7] No-recharge variant waits in standby
// [R8] Restart only on battery, supply, resistor reconnect
// [R9] Thermal regulation reduces current when hot
// [R10] Suspend charging above die shutdown temperature
// [R11] Resume only after die cools hysteresis
// [R12] Status open-drain: low or released
// [R13] Status released in shutdown and standby states
// [R14] Status low charging; faults flash or release
// [R15] Battery short: postpone, supply recovery current
// [R16] Leave short only above hysteresis threshold
// [R17] Precondition timeout latches timer fault
// [R18] Precondition supplies tenth of fast current
// [R19] Elapse timer restarts on fast charge entry
// [R20] Flash: equal low and released phases
`timescale 1ns/100ps
`include "dcs_defines.vh"

module dcs_sequencer #(
    parameter FILT_CYC = `DCS_TERM_FILT_CYC,
    parameter FLASH_HALF_CYC = `DCS_FLASH_HALF_CYC,
    parameter SEC_CYC = `DCS_SEC_CYC,
    parameter PRE_TMR_SEC = `DCS_PRE_TMR_MIN * 60,
    parameter ELAPSE_SEC = `DCS_ELAPSE_HR * 3600,
    parameter ELAPSE_EN = 1,
    parameter PRE_TMR_EN = 1,
    parameter PRECOND_EN = 1,
    parameter RECHARGE_EN = 1,
    parameter FLASH_TYPE = 1
)(
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Supply and presence qualifiers
    input wire supply_ok,
    input wire battery_present,
    input wire current_program_pin_ok,
    // Battery voltage comparators
    input wire vbat_below_short_protect,
    input wire vbat_above_short_release,
    input wire vbat_below_precond,
    input wire vbat_at_regulation_voltage,
    input wire vbat_below_recharge,
    // Current and thermal comparators
    input wire cur_below_term,
    input wire die_over_shutdown,
    input wire die_cooled,
    input wire die_over_regulation,
    // Factory option
    input wire [1:0] term_ratio_sel,
    // Charger control
    output reg [1:0] current_level,
    output reg cv_mode,
    output reg thermal_fold_back,
    output reg [1:0] term_ratio,
    // Status pin, open-drain
    output wire stat_out,
    output wire stat_oe_b,
    // State observation
    output reg [9:0] state_out
);

    // One-hot charge states
    localparam [9:0] ST_SHUTDOWN = 10'h001;
    localparam [9:0] ST_STANDBY = 10'h002;
    localparam [9:0] ST_SHORT = 10'h004;
    localparam [9:0] ST_PRECOND = 10'h008;
    localparam [9:0] ST_FAST = 10'h010;
    localparam [9:0] ST_CV = 10'h020;
    localparam [9:0] ST_DONE = 10'h040;
    localparam [9:0] ST_TEMP_FLT = 10'h080;
    localparam [9:0] ST_TMR_FLT = 10'h100;
    localparam [9:0] ST_PRE_FLT = 10'h200;

    reg [9:0] state_r; // Current charge state
    reg [9:0] state_nxt; // Next charge state
    reg [9:0] resume_r; // Charging state held across thermal shutdown
    reg [24:0] sec_cnt_r; // Prescaler for one-second ticks
    reg sec_tick_r; // One-cycle pulse each second
    reg [15:0] tmr_r; // Seconds since entering precondition or fast charge
    reg [24:0] flash_cnt_r; // Flash phase counter
    reg flash_low_r; // Flash phase: 1 pulls low
    reg stat_low_r; // Registered pull-low request
    reg done_latch_r; // Terminated with no recharge allowed
    wire term_filt; // Filtered termination comparator
    wire restart_ev; // Battery, supply or resistor dropout seen
    wire tmr_clr; // Restart cycle timer
    wire elapse_exp; // Elapse timer ran out
    wire pre_exp; // Precondition timer ran out
    wire term_raw; // Comparator gated to constant voltage

    // Only a comparator result seen in constant voltage feeds the filter,
    // so a result left over from an earlier cycle cannot end the next one
    assign term_raw = cur_below_term && (state_r == ST_CV); // [R2]

    // Comparator must persist before termination may act
    dcs_filter #(
        .LEN(FILT_CYC),
        .CW(16)
    ) u_term_filt (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .raw_in(term_raw),
        .filt_out(term_filt)
    ); // [R4]

    // Any of the three qualifiers dropping forces a fresh cycle
    // Dropouts are levels, so the latch stays clear while they last
    assign restart_ev = ~supply_ok | ~battery_present |
        ~current_program_pin_ok; // [R8]

    // Timer restarts on entry to precondition or fast charge
    assign tmr_clr = (state_r != ST_FAST && state_nxt == ST_FAST) ||
        (state_r != ST_PRECOND && state_nxt == ST_PRECOND); // [R19]

    // A disabled elapse timer never ends a cycle
    assign elapse_exp = (ELAPSE_EN != 0) &&
        (tmr_r >= ELAPSE_SEC[15:0]); // [R5]
    // Precondition limit; the disabled variant never faults
    assign pre_exp = (PRE_TMR_EN != 0) && (tmr_r >= PRE_TMR_SEC[15:0]);

    // One-second enable pulse from the 20 MHz clock
    // A pulse, not a derived clock, keeps every counter on ref_clk
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sec_cnt_r <= 25'h0000000;
            sec_tick_r <= 1'b0;
        end
        else if (sec_cnt_r >= SEC_CYC[24:0] - 1'b1)
        begin
            sec_cnt_r <= 25'h0000000;
            sec_tick_r <= 1'b1;
        end
        else
        begin
            sec_cnt_r <= sec_cnt_r + 1'b1;
            sec_tick_r <= 1'b0;
        end
    end

    // Cycle timer; saturates so it never wraps back to zero
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            tmr_r <= 16'h0000;
        else if (tmr_clr)
            tmr_r <= 16'h0000; // [R19]
        // Counts only in precondition, fast charge and constant voltage; paused in faults
        else if (sec_tick_r && tmr_r != 16'hFFFF &&
            (state_r == ST_PRECOND || state_r == ST_FAST ||
            state_r == ST_CV))
            tmr_r <= tmr_r + 1'b1;
    end

    // Next-state logic; qualifier loss has top priority
    always @*
    begin
        state_nxt = state_r;
        if (!supply_ok || !current_program_pin_ok)
            state_nxt = ST_SHUTDOWN; // [R8]
        else if (!battery_present)
            state_nxt = ST_STANDBY; // [R8]
        else
        begin
            case (state_r)
                ST_SHUTDOWN, ST_STANDBY:
                begin
                    // A no-recharge finish waits for a reconnect
                    if (!done_latch_r && vbat_below_recharge)
                        state_nxt = ST_SHORT; // [R7]
                end
                ST_SHORT:
                begin
                    // Recovery current flows until the pack climbs out
                    // Leave only above the release threshold
                    if (vbat_above_short_release)
                        state_nxt = (PRECOND_EN != 0) ? ST_PRECOND :
                            ST_FAST; // [R16]
                end
                ST_PRECOND:
                begin
                    // Overheat first, then a short, threshold, timer
                    if (die_over_shutdown)
                        state_nxt = ST_TEMP_FLT; // [R10]
                    else if (vbat_below_short_protect)
                        state_nxt = ST_SHORT; // [R15]
                    else if (!vbat_below_precond)
                        state_nxt = ST_FAST;
                    else if (pre_exp)
                        state_nxt = ST_PRE_FLT; // [R17]
                end
                ST_FAST:
                begin
                    // Timer expiry outranks reaching regulation voltage
                    if (die_over_shutdown)
                        state_nxt = ST_TEMP_FLT; // [R10]
                    else if (vbat_below_short_protect)
                        state_nxt = ST_SHORT; // [R15]
                    else if (elapse_exp)
                        state_nxt = ST_TMR_FLT; // [R3]
                    else if (vbat_at_regulation_voltage)
                        state_nxt = ST_CV; // [R1]
                end
                ST_CV:
                begin
                    // Either the filtered current or the timer ends it
                    if (die_over_shutdown)
                        state_nxt = ST_TEMP_FLT; // [R10]
                    else if (term_filt || elapse_exp)
                        state_nxt = (RECHARGE_EN != 0) ? ST_DONE :
                            ST_STANDBY; // [R2] [R3] [R7]
                end
                ST_DONE:
                begin
                    // Watch battery for the recharge threshold
                    if (vbat_below_recharge)
                        state_nxt = ST_FAST; // [R6]
                end
                ST_TEMP_FLT:
                begin
                    // The cycle timer keeps its count only on a resume into constant voltage; precondition or fast restarts it
                    // Hysteresis: wait for the cooled comparator
                    if (die_cooled && !die_over_shutdown)
                        state_nxt = resume_r; // [R11]
                end
                ST_TMR_FLT, ST_PRE_FLT:
                begin
                    // No battery voltage or timer event leaves a fault
                    // Held until a qualifier drops
                    state_nxt = state_r; // [R17]
                end
                // Illegal code: fall back to shutdown
                default:
                    state_nxt = ST_SHUTDOWN;
            endcase
        end
    end

    // State register, resume point and no-recharge latch
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_SHUTDOWN;
            resume_r <= ST_PRECOND;
            done_latch_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            // Remember where charging stood so cooling can resume there
            if (state_nxt == ST_TEMP_FLT && state_r != ST_TEMP_FLT)
                resume_r <= state_r; // [R10]
            // Clear wins over set: a pack pulled during constant voltage
            // also lands in standby and must not lock out the next cycle
            if (restart_ev)
                done_latch_r <= 1'b0; // [R8]
            else if (state_r == ST_CV && state_nxt == ST_STANDBY)
                done_latch_r <= 1'b1; // [R7]
        end
    end

    // Flash phases start low on every fault entry
    // Counter runs in every state; only faults use the phase
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flash_cnt_r <= 25'h0000000;
            flash_low_r <= 1'b1;
        end
        else if (state_nxt != state_r)
        begin
            flash_cnt_r <= 25'h0000000;
            flash_low_r <= 1'b1; // [R20]
        end
        else if (flash_cnt_r >= FLASH_HALF_CYC[24:0] - 1'b1)
        begin
            flash_cnt_r <= 25'h0000000;
            // Half period over: swap phase
            flash_low_r <= ~flash_low_r; // [R20]
        end
        else
            flash_cnt_r <= flash_cnt_r + 1'b1;
    end

    // Registered outputs decoded from the state; term ratio follows the selector
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            current_level <= `DCS_CUR_OFF;
            cv_mode <= 1'b0;
            thermal_fold_back <= 1'b0;
            term_ratio <= `DCS_TERM_5;
            stat_low_r <= 1'b0;
            state_out <= ST_SHUTDOWN;
        end
        else
        begin
            state_out <= state_r;
            term_ratio <= term_ratio_sel; // [R2]
            // Mode flag for the regulation loop
            cv_mode <= (state_r == ST_CV); // [R1]
            // Fold back only in precondition, fast charge and constant voltage
            thermal_fold_back <= die_over_regulation &&
                (state_r == ST_PRECOND || state_r == ST_FAST ||
                state_r == ST_CV); // [R9]
            // Current request follows the state; idle and faults cut it
            case (state_r)
                ST_SHORT:
                    current_level <= `DCS_CUR_SHORT; // [R15]
                ST_PRECOND:
                    current_level <= `DCS_CUR_PRE; // [R18]
                ST_FAST, ST_CV:
                    current_level <= `DCS_CUR_FAST;
                default:
                    current_level <= `DCS_CUR_OFF; // [R10]
            endcase
            // Status: low while charging, flash or release in faults
            case (state_r)
                ST_PRECOND, ST_FAST, ST_CV:
                    stat_low_r <= 1'b1; // [R14]
                ST_TEMP_FLT, ST_TMR_FLT, ST_PRE_FLT:
                    stat_low_r <= (FLASH_TYPE != 0) && flash_low_r; // [R14]
                default:
                    stat_low_r <= 1'b0; // [R13]
            endcase
        end
    end

    // Open-drain: data always low, enable active low pulls the pin
    // Only the enable moves, so the pin is never driven high
    assign stat_out = 1'b0; // [R12]
    assign stat_oe_b = ~stat_low_r; // [R12]

endmodule

// [rtl/dcs_defines.vh]
`ifndef DCS_DEFINES_VH
`define DCS_DEFINES_VH
// Reference clock rate in Hz
`define DCS_CLK_HZ 20000000
// Termination comparator filter time in microseconds
`define DCS_TERM_FILT_US 1000
// Filter length in cycles, a least time rounded up
`define DCS_TERM_FILT_CYC ((`DCS_TERM_FILT_US * (`DCS_CLK_HZ / 1000000)) + 0)
// Fault flash half period in milliseconds (0.8 s of a 1.6 s period)
`define DCS_FLASH_HALF_MS 800
// Flash half period in cycles, a longest time rounded down
`define DCS_FLASH_HALF_CYC (`DCS_FLASH_HALF_MS * (`DCS_CLK_HZ / 1000))
// Precondition timer in minutes
`define DCS_PRE_TMR_MIN 32
// Elapse timer default in hours
`define DCS_ELAPSE_HR 6
// Seconds prescaler length in cycles
`define DCS_SEC_CYC `DCS_CLK_HZ
// Termination ratio selector codes
`define DCS_TERM_5 2'h0
`define DCS_TERM_7P5 2'h1
`define DCS_TERM_10 2'h2
`define DCS_TERM_20 2'h3
// Charge current level codes
`define DCS_CUR_OFF 2'h0
`define DCS_CUR_SHORT 2'h1
`define DCS_CUR_PRE 2'h2
`define DCS_CUR_FAST 2'h3
`endif

// [rtl/dcs_filter.v]
`timescale 1ns/100ps
`include "dcs_defines.vh"

// Persistence filter: output rises only after the input has held high,
// and falls at once when the input drops
module dcs_filter #(
    parameter LEN = `DCS_TERM_FILT_CYC,
    parameter CW = 16
)(
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Raw and filtered level
    input wire raw_in,
    output reg filt_out
);

    reg [CW-1:0] cnt_r; // Cycles the input has differed from output

    // Restart the count on every mismatch gap so glitches never pass
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_r <= {CW{1'b0}};
            filt_out <= 1'b0;
        end
        else if (!raw_in)
        begin
            // A low input drops the output at once, so no stale result
            cnt_r <= {CW{1'b0}};
            filt_out <= 1'b0;
        end
        else if (filt_out)
        begin
            // Already accepted: hold with no count
            cnt_r <= {CW{1'b0}};
        end
        else if (cnt_r >= LEN[CW-1:0] - 1'b1)
        begin
            // Held long enough: accept the new level
            cnt_r <= {CW{1'b0}};
            filt_out <= raw_in;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

endmodule

// [sim/dcs_chk.sv]
`timescale 1ns/100ps
// Port-level checker for the charge sequencer
module dcs_chk #(
    parameter FLASH_TYPE = 1
)(
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Observed ports
    input wire die_over_shutdown,
    input wire [1:0] current_level,
    input wire cv_mode,
    input wire stat_out,
    input wire stat_oe_b,
    input wire [9:0] state_out
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Charging states pull the pin low
    property p_stat_low;
        (state_out & 10'h038) != 10'h000 |-> !stat_oe_b;
    endproperty
    // Idle states release the pin
    property p_stat_rel;
        (state_out & 10'h043) != 10'h000 |-> stat_oe_b;
    endproperty
    // Pin is open-drain, so it never drives high
    property p_od;
        !stat_out;
    endproperty
    property p_short_cur;
        state_out == 10'h004 |-> current_level == 2'h1;
    endproperty
    property p_pre_cur;
        state_out == 10'h008 |-> current_level == 2'h2;
    endproperty
    property p_cv;
        state_out == 10'h020 |-> cv_mode && current_level != 2'h0;
    endproperty
    // Overheat in fast charge reaches the fault within three edges
    property p_hot;
        state_out == 10'h010 && die_over_shutdown |-> ##[1:3]
            state_out == 10'h080;
    endproperty
    // Every fault state cuts the current
    property p_fault_off;
        state_out[9:7] != 3'h0 |-> current_level == 2'h0;
    endproperty
    // A low flash phase in thermal fault lasts at least eight cycles
    property p_flash;
        FLASH_TYPE != 0 && state_out[7] && $fell(stat_oe_b) |->
            (!stat_oe_b)[*8];
    endproperty
    a_stat_low: assert property (p_stat_low) else $error("pin not low");
    a_stat_rel: assert property (p_stat_rel) else $error("pin not off");
    a_od: assert property (p_od) else $error("pin driven high");
    a_short_cur: assert property (p_short_cur) else $error("short cur");
    a_pre_cur: assert property (p_pre_cur) else $error("precond cur");
    a_cv: assert property (p_cv) else $error("cv mode flag");
    a_hot: assert property (p_hot) else $error("no thermal stop");
    a_fault_off: assert property (p_fault_off) else $error("fault cur");
    a_flash: assert property (p_flash) else $error("flash phase");
    c_done: cover property (state_out == 10'h040);
    c_hot: cover property (state_out == 10'h080);
    c_tmr: cover property (state_out == 10'h200);
endmodule
bind dcs_sequencer dcs_chk #(.FLASH_TYPE(FLASH_TYPE)) u_dcs_chk (
    .ref_clk(ref_clk), .rst_b(rst_b),
    .die_over_shutdown(die_over_shutdown),
    .current_level(current_level), .cv_mode(cv_mode),
    .stat_out(stat_out), .stat_oe_b(stat_oe_b), .state_out(state_out));

// [sim/dcs_batt_model.sv]
`timescale 1ns/100ps
// Battery pack comparators and pulled-up status line
module dcs_batt_model #(
    parameter SHORT_MV = 1700,
    parameter REL_MV = 1850,
    parameter PRE_MV = 6000,
    parameter REG_MV = 8400,
    parameter RCH_MV = 7980
)(
    // Pack voltage in millivolts
    input wire [15:0] vbat_mv,
    // Status pin from the sequencer
    input wire stat_out,
    input wire stat_oe_b,
    // Comparator results
    output wire below_short,
    output wire above_rel,
    output wire below_pre,
    output wire at_reg,
    output wire below_rch,
    // Resolved pin level
    output wire stat_pin
);
    // Short band has hysteresis so recovery needs a real rise
    assign below_short = vbat_mv < SHORT_MV;
    assign above_rel = vbat_mv > REL_MV;
    assign below_pre = vbat_mv < PRE_MV;
    assign at_reg = vbat_mv >= REG_MV;
    assign below_rch = vbat_mv < RCH_MV;
    // Pull-up wins whenever the driver lets go
    assign stat_pin = stat_oe_b ? 1'b1 : stat_out;
endmodule

// [sim/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    reg ref_clk, rst_b, supply_ok, batt, pin_ok, cur_low, hot, cooled, warm;
    reg [1:0] sel;
    reg [15:0] vbat;
    wire bs, br, bp, ar, brc, stat_out, stat_oe_b, stat_pin, cv_mode, tfb;
    wire [1:0] current_level, term_ratio;
    wire [9:0] state_out;
    wire [9:0] state_out_nr;
    wire stat_oe_b_nr;
    integer fail_count, compares, i, n;
    // Short counts keep the run brief; elapse is 200 cycles
    dcs_sequencer #(.FILT_CYC(8), .FLASH_HALF_CYC(10), .SEC_CYC(4),
        .PRE_TMR_SEC(5), .ELAPSE_SEC(50)) u_dcs_sequencer (
        .ref_clk(ref_clk), .rst_b(rst_b), .supply_ok(supply_ok),
        .battery_present(batt), .current_program_pin_ok(pin_ok),
        .vbat_below_short_protect(bs), .vbat_above_short_release(br),
        .vbat_below_precond(bp), .vbat_at_regulation_voltage(ar),
        .vbat_below_recharge(brc), .cur_below_term(cur_low),
        .die_over_shutdown(hot), .die_cooled(cooled),
        .die_over_regulation(warm), .term_ratio_sel(sel),
        .current_level(current_level), .cv_mode(cv_mode),
        .thermal_fold_back(tfb), .term_ratio(term_ratio),
        .stat_out(stat_out), .stat_oe_b(stat_oe_b), .state_out(state_out));
    dcs_batt_model u_dcs_batt_model (.vbat_mv(vbat), .stat_out(stat_out),
        .stat_oe_b(stat_oe_b), .below_short(bs), .above_rel(br),
        .below_pre(bp), .at_reg(ar), .below_rch(brc), .stat_pin(stat_pin));
    // Variant with no recharge and a steady status output
    dcs_sequencer #(.FILT_CYC(8), .FLASH_HALF_CYC(10), .SEC_CYC(4),
        .PRE_TMR_SEC(5), .ELAPSE_SEC(50), .RECHARGE_EN(0),
        .FLASH_TYPE(0)) u_dcs_sequencer_nr (
        .ref_clk(ref_clk), .rst_b(rst_b), .supply_ok(supply_ok),
        .battery_present(batt), .current_program_pin_ok(pin_ok),
        .vbat_below_short_protect(bs), .vbat_above_short_release(br),
        .vbat_below_precond(bp), .vbat_at_regulation_voltage(ar),
        .vbat_below_recharge(brc), .cur_below_term(cur_low),
        .die_over_shutdown(hot), .die_cooled(cooled),
        .die_over_regulation(warm), .term_ratio_sel(sel),
        .current_level(), .cv_mode(), .thermal_fold_back(),
        .term_ratio(), .stat_out(), .stat_oe_b(stat_oe_b_nr),
        .state_out(state_out_nr));
    // Free-running reference clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp)
            begin
                fail_count = fail_count + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Bounded poll for a state, sampled on falling edges
    task go(input [15:0] mv, input [9:0] exp, input integer lim);
        begin
            vbat = mv;
            n = 0;
            while (state_out !== exp && n < lim)
            begin
                @(negedge ref_clk);
                n = n + 1;
            end
            chk(state_out, exp);
        end
    endtask
    task t_cycle;
        begin
            go(16'h2328, 10'h001, 4);
            chk(stat_pin, 1'b1);
            go(16'h05DC, 10'h004, 4);
            go(16'h0708, 10'h004, 4);
            go(16'h076C, 10'h008, 4);
            chk(stat_pin, 1'b0);
            chk(current_level, 2'h2);
            go(16'h1B58, 10'h010, 4);
            chk(current_level, 2'h3);
            go(16'h20D0, 10'h020, 4);
            // A short dip must not end the cycle
            cur_low = 1'b1;
            repeat (5) @(negedge ref_clk);
            cur_low = 1'b0;
            repeat (6) @(negedge ref_clk);
            chk(state_out, 10'h020);
            cur_low = 1'b1;
            go(16'h20D0, 10'h040, 14);
            chk(state_out_nr, 10'h002);
            chk(stat_pin, 1'b1);
            cur_low = 1'b0;
            go(16'h1EDC, 10'h010, 4);
            chk(state_out_nr, 10'h002);
            go(16'h20D0, 10'h020, 4);
            repeat (180) @(negedge ref_clk);
            chk(state_out, 10'h020);
            go(16'h20D0, 10'h040, 80);
            $display("t_cycle finished");
        end
    endtask
    task t_pre_fault;
        begin
            batt = 1'b0;
            go(16'h0BB8, 10'h002, 4);
            batt = 1'b1;
            go(16'h0BB8, 10'h200, 40);
            chk(current_level, 2'h0);
            // Wait out the low phase, then time the released one
            for (n = 0; n < 20 && stat_pin !== 1'b1; n = n + 1)
                @(negedge ref_clk);
            for (i = 0; i < 30 && stat_pin === 1'b1; i = i + 1)
                @(negedge ref_clk);
            chk(i, 10);
            go(16'h1B58, 10'h200, 30);
            chk(state_out_nr, 10'h200);
            chk(stat_oe_b_nr, 1'b1);
            pin_ok = 1'b0;
            go(16'h0BB8, 10'h001, 4);
            pin_ok = 1'b1;
            go(16'h0BB8, 10'h008, 6);
            supply_ok = 1'b0;
            go(16'h0BB8, 10'h001, 4);
            supply_ok = 1'b1;
            batt = 1'b0;
            go(16'h0BB8, 10'h002, 4);
            $display("t_pre_fault finished");
        end
    endtask
    task t_therm;
        begin
            batt = 1'b1;
            go(16'h0BB8, 10'h008, 8);
            go(16'h1B58, 10'h010, 4);
            hot = 1'b1;
            cooled = 1'b0;
            go(16'h1B58, 10'h080, 4);
            chk(current_level, 2'h0);
            repeat (30) @(negedge ref_clk);
            hot = 1'b0;
            repeat (5) @(negedge ref_clk);
            chk(state_out, 10'h080);
            cooled = 1'b1;
            go(16'h1B58, 10'h010, 4);
            warm = 1'b1;
            repeat (3) @(negedge ref_clk);
            chk(tfb, 1'b1);
            warm = 1'b0;
            for (i = 0; i < 4; i = i + 1)
            begin
                sel = i[1:0];
                repeat (3) @(negedge ref_clk);
                chk(term_ratio, i);
            end
            $display("t_therm finished");
        end
    endtask
    task stop_test;
        begin
            $display("compares=%0d fail_count=%0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // Main sequence; inputs move on falling edges only
    initial
    begin
        fail_count = 0;
        compares = 0;
        rst_b = 1'b0;
        supply_ok = 1'b1;
        batt = 1'b1;
        pin_ok = 1'b1;
        vbat = 16'h2328;
        cur_low = 1'b0;
        hot = 1'b0;
        cooled = 1'b1;
        warm = 1'b0;
        sel = 2'h2;
        repeat (10) @(negedge ref_clk);
        rst_b = 1'b1;
        t_cycle;
        t_pre_fault;
        t_therm;
        stop_test;
    end
    // Watchdog well beyond the roughly 400 cycles of tests
    initial
    begin
        #200000;
        fail_count = fail_count + 1;
        stop_test;
    end
endmodule
